// ===== pmta_table_access.v
// Behaviour
// - fetch and table reads use separate memory ports
// - 21-bit fetch address, unimplemented space reads zero
// - reset vector 0000h, interrupt vectors 0008h, 0018h
// - unlock port stores nothing, reads zero
// - region select routes operations to three spaces
// - erase select makes next start erase flash
// - program/erase only with write allow; reset clears
// - fault flag set on start, cleared on completion
// - start launches eeprom erase/write, flash erase/write or config write
// - firmware sets start only; hardware clears it
// - completion sets done flag until firmware clears
// - 8-bit table latch in register space
// - three bytes form 22-bit pointer; top selects config
// - table ops update only low 21 pointer bits
// - table read uses 22 bits, loads latch
// - table write fills holding slot from low bits
// - flash write stores block at upper pointer bits
`timescale 1ns/1ps
`include "pmta_defs.vh"

module pmta_table_access #(
    parameter PROG_BYTES = 32'h00010000,
    parameter SLOT_BITS = 5,
    parameter PROG_TIME_US = `PMTA_PROG_TIME_US,
    parameter CLK_MHZ = `PMTA_CLK_MHZ
) (
    input wire clk_in,
    input wire rst_n_in,
    // instruction fetch path
    input wire [`PMTA_PC_W-1:0] fetch_addr_in,
    output wire [`PMTA_PC_W-1:0] fetch_mem_addr_out,
    input wire [15:0] fetch_mem_data_in,
    output reg [15:0] fetch_data_out,
    // vectors
    output wire [`PMTA_PC_W-1:0] reset_vector_out,
    output wire [`PMTA_PC_W-1:0] high_vector_out,
    output wire [`PMTA_PC_W-1:0] low_vector_out,
    // special function register port
    input wire [2:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    // table operations from the core
    input wire table_read_op_in,
    input wire table_write_op_in,
    input wire [1:0] table_update_in,
    output wire table_busy_out,
    output reg [`PMTA_PTR_W-1:0] table_mem_addr_out,
    input wire [7:0] table_mem_data_in,
    // nonvolatile operation port
    output reg nv_start_out,
    output reg [1:0] nv_kind_out,
    output reg [`PMTA_PTR_W-1:0] nv_addr_out,
    output reg [7:0] nv_byte_out,
    output wire [(8<<SLOT_BITS)-1:0] nv_block_out,
    output wire memory_done_flag_out
);
    // ----------------------------------------
    // derived constants and states
    // ----------------------------------------
    localparam PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // beyond the implemented array the core must see a no-operation
    function [15:0] fill_word;
        input [`PMTA_PC_W-1:0] addr;
        input [15:0] data;
        begin
            if ({11'h000, addr} < PROG_BYTES) begin
                fill_word = data;
            end else begin
                fill_word = 16'h0000;
            end
        end
    endfunction

    // top bit is carried unchanged, only the program space part moves
    function [`PMTA_PTR_W-1:0] step_ptr;
        input [`PMTA_PTR_W-1:0] ptr;
        input dec;
        reg [`PMTA_PC_W-1:0] low;
        begin
            if (dec) begin
                low = ptr[`PMTA_PC_W-1:0] - 21'h000001;
            end else begin
                low = ptr[`PMTA_PC_W-1:0] + 21'h000001;
            end
            step_ptr = {ptr[`PMTA_PTR_TOP], low};
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] region_select;
    reg erase_sel;
    reg write_allow;
    reg write_start;
    reg write_fault_flag;
    reg memory_done_flag;
    reg [7:0] table_latch;
    reg [`PMTA_PTR_W-1:0] table_pointer;
    reg [`PMTA_PTR_W-1:0] op_ptr;
    reg [`PMTA_PTR_W-1:0] post_ptr;
    reg [SLOT_BITS-1:0] hold_slot;
    reg hold_wr;
    reg hold_clear;
    reg timer_start;
    wire timer_busy;
    wire timer_done;
    wire ctrl_wr;
    wire start_req;
    wire start_ok;
    wire table_idle;

    assign ctrl_wr = sfr_wr_in && (sfr_addr_in == `PMTA_REG_CTRL);
    assign start_req = ctrl_wr && sfr_wdata_in[`PMTA_CTRL_START];
    assign start_ok = start_req && write_allow && !write_start && !timer_busy;
    assign table_idle = (state == ST_IDLE);
    assign table_busy_out = !table_idle;
    assign memory_done_flag_out = memory_done_flag;

    // ----------------------------------------
    // vectors
    // ----------------------------------------
    assign reset_vector_out = `PMTA_VEC_RESET;
    assign high_vector_out = `PMTA_VEC_HIGH;
    assign low_vector_out = `PMTA_VEC_LOW;

    // ----------------------------------------
    // instruction fetch port
    // ----------------------------------------
    // own address bus, so a table op never stalls a fetch
    assign fetch_mem_addr_out = fetch_addr_in;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fetch_data_out <= 16'h0000;
        end else begin
            fetch_data_out <= fill_word(fetch_addr_in, fetch_mem_data_in);
        end
    end

    // ----------------------------------------
    // table op address selection
    // ----------------------------------------
    always @* begin
        op_ptr = table_pointer;
        post_ptr = table_pointer;
        case (table_update_in)
            `PMTA_UPD_NONE: post_ptr = table_pointer;
            `PMTA_UPD_POST_INC: post_ptr = step_ptr(table_pointer, 1'b0);
            `PMTA_UPD_POST_DEC: post_ptr = step_ptr(table_pointer, 1'b1);
            `PMTA_UPD_PRE_INC: begin
                op_ptr = step_ptr(table_pointer, 1'b0);
                post_ptr = op_ptr;
            end
            default: post_ptr = table_pointer;
        endcase
    end

    // ----------------------------------------
    // table state machine
    // ----------------------------------------
    always @* begin
        next_state = state;
        hold_wr = 1'b0;
        hold_slot = op_ptr[SLOT_BITS-1:0];
        case (state)
            ST_IDLE: begin
                if (table_read_op_in) begin
                    next_state = ST_READ;
                end else if (table_write_op_in) begin
                    hold_wr = 1'b1;
                end
            end
            ST_READ: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            table_mem_addr_out <= {`PMTA_PTR_W{1'b0}};
        end else begin
            state <= next_state;
            if (table_idle && table_read_op_in) begin
                table_mem_addr_out <= op_ptr;
            end
        end
    end

    // ----------------------------------------
    // holding block
    // ----------------------------------------
    pmta_hold_block #(
        .SLOT_BITS(SLOT_BITS)
    ) u_hold (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(hold_wr),
        .slot_in(hold_slot),
        .byte_in(table_latch),
        .clear_in(hold_clear),
        .block_out(nv_block_out)
    );

    // ----------------------------------------
    // latch and pointer
    // ----------------------------------------
    // sfr writes and table ops on the same edge: the table op wins
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            table_latch <= 8'h00;
            table_pointer <= {`PMTA_PTR_W{1'b0}};
        end else begin
            if (state == ST_READ) begin
                if (table_mem_addr_out[`PMTA_PTR_TOP]) begin
                    table_latch <= table_mem_data_in;
                end else if ({10'h000, table_mem_addr_out[`PMTA_PC_W-1:0]} < PROG_BYTES) begin
                    table_latch <= table_mem_data_in;
                end else begin
                    table_latch <= 8'h00;
                end
            end else if (sfr_wr_in && sfr_addr_in == `PMTA_REG_LATCH) begin
                table_latch <= sfr_wdata_in;
            end
            if (table_idle && (table_read_op_in || table_write_op_in)) begin
                table_pointer <= post_ptr;
            end else if (sfr_wr_in) begin
                case (sfr_addr_in)
                    `PMTA_REG_PTR_LOW: table_pointer[7:0] <= sfr_wdata_in;
                    `PMTA_REG_PTR_HIGH: table_pointer[15:8] <= sfr_wdata_in;
                    `PMTA_REG_PTR_UPPER: table_pointer[21:16] <= sfr_wdata_in[5:0];
                    default: table_pointer <= table_pointer;
                endcase
            end
        end
    end

    // ----------------------------------------
    // programming timer
    // ----------------------------------------
    pmta_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(timer_start),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    // ----------------------------------------
    // memory_access_control
    // ----------------------------------------
    // region and erase select are frozen while a cycle runs, so the
    // operation reported at the start matches the one that completes
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            region_select <= `PMTA_REGION_EEPROM;
            erase_sel <= 1'b0;
            write_allow <= 1'b0;
            write_start <= 1'b0;
            write_fault_flag <= 1'b0;
            timer_start <= 1'b0;
        end else begin
            timer_start <= 1'b0;
            if (ctrl_wr) begin
                write_allow <= sfr_wdata_in[`PMTA_CTRL_ALLOW];
                if (!write_start) begin
                    region_select <= sfr_wdata_in[`PMTA_CTRL_REGION_HI:`PMTA_CTRL_REGION_LO];
                    erase_sel <= sfr_wdata_in[`PMTA_CTRL_ERASE];
                end
            end
            if (start_ok) begin
                write_start <= 1'b1;
                write_fault_flag <= 1'b1;
                timer_start <= 1'b1;
            end else if (timer_done) begin
                write_start <= 1'b0;
                write_fault_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // nonvolatile operation launch
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_start_out <= 1'b0;
            nv_kind_out <= `PMTA_OP_EEPROM;
            nv_addr_out <= {`PMTA_PTR_W{1'b0}};
            nv_byte_out <= 8'h00;
            hold_clear <= 1'b0;
        end else begin
            nv_start_out <= start_ok;
            hold_clear <= 1'b0;
            if (start_ok) begin
                nv_byte_out <= table_latch;
                if (sfr_wdata_in[`PMTA_CTRL_REGION_LO]) begin
                    nv_kind_out <= `PMTA_OP_CONFIG;
                    nv_addr_out <= table_pointer;
                end else if (sfr_wdata_in[`PMTA_CTRL_REGION_HI]) begin
                    // slot bits are dropped, the block lands on its boundary
                    nv_addr_out <= {table_pointer[`PMTA_PTR_W-1:SLOT_BITS], {SLOT_BITS{1'b0}}};
                    hold_clear <= !sfr_wdata_in[`PMTA_CTRL_ERASE];
                    if (sfr_wdata_in[`PMTA_CTRL_ERASE]) begin
                        nv_kind_out <= `PMTA_OP_FLASH_ERASE;
                    end else begin
                        nv_kind_out <= `PMTA_OP_FLASH_WRITE;
                    end
                end else begin
                    nv_kind_out <= `PMTA_OP_EEPROM;
                    nv_addr_out <= table_pointer;
                end
            end
        end
    end

    // ----------------------------------------
    // done flag in peripheral_flags_seven
    // ----------------------------------------
    // completion on the same edge as a firmware clear keeps the flag set
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            memory_done_flag <= 1'b0;
        end else if (timer_done) begin
            memory_done_flag <= 1'b1;
        end else if (sfr_wr_in && sfr_addr_in == `PMTA_REG_FLAGS7 && !sfr_wdata_in[`PMTA_FLAGS7_DONE]) begin
            memory_done_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // register read path
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            case (sfr_addr_in)
                `PMTA_REG_CTRL: sfr_rdata_out <= {region_select, 1'b0, erase_sel, write_fault_flag,
                                                  write_allow, write_start, 1'b0};
                `PMTA_REG_UNLOCK: sfr_rdata_out <= 8'h00;
                `PMTA_REG_LATCH: sfr_rdata_out <= table_latch;
                `PMTA_REG_PTR_LOW: sfr_rdata_out <= table_pointer[7:0];
                `PMTA_REG_PTR_HIGH: sfr_rdata_out <= table_pointer[15:8];
                `PMTA_REG_PTR_UPPER: sfr_rdata_out <= {2'b00, table_pointer[21:16]} & `PMTA_PTR_UPPER_MASK;
                `PMTA_REG_FLAGS7: sfr_rdata_out <= {2'b00, memory_done_flag, 5'b00000};
                default: sfr_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule

// ===== pmta_defs.vh
`ifndef PMTA_DEFS_VH
`define PMTA_DEFS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define PMTA_PC_W 21
`define PMTA_PTR_W 22
`define PMTA_PTR_TOP 21

// ----------------------------------------
// vectors
// ----------------------------------------
`define PMTA_VEC_RESET 21'h000000
`define PMTA_VEC_HIGH 21'h000008
`define PMTA_VEC_LOW 21'h000018

// ----------------------------------------
// special function register indices
// ----------------------------------------
`define PMTA_REG_CTRL 3'h0
`define PMTA_REG_UNLOCK 3'h1
`define PMTA_REG_LATCH 3'h2
`define PMTA_REG_PTR_LOW 3'h3
`define PMTA_REG_PTR_HIGH 3'h4
`define PMTA_REG_PTR_UPPER 3'h5
`define PMTA_REG_FLAGS7 3'h6

// ----------------------------------------
// memory_access_control fields
// ----------------------------------------
`define PMTA_CTRL_REGION_HI 7
`define PMTA_CTRL_REGION_LO 6
`define PMTA_CTRL_ERASE 4
`define PMTA_CTRL_FAULT 3
`define PMTA_CTRL_ALLOW 2
`define PMTA_CTRL_START 1
`define PMTA_CTRL_RESET 8'h00
`define PMTA_FLAGS7_DONE 5
`define PMTA_PTR_UPPER_MASK 8'h3f

// ----------------------------------------
// region_select codes
// ----------------------------------------
`define PMTA_REGION_EEPROM 2'h0
`define PMTA_REGION_FLASH 2'h2

// ----------------------------------------
// pointer update modes of table ops
// ----------------------------------------
`define PMTA_UPD_NONE 2'h0
`define PMTA_UPD_POST_INC 2'h1
`define PMTA_UPD_POST_DEC 2'h2
`define PMTA_UPD_PRE_INC 2'h3

// ----------------------------------------
// nonvolatile operation kinds
// ----------------------------------------
`define PMTA_OP_EEPROM 2'h0
`define PMTA_OP_FLASH_WRITE 2'h1
`define PMTA_OP_FLASH_ERASE 2'h2
`define PMTA_OP_CONFIG 2'h3

// ----------------------------------------
// programming timer
// ----------------------------------------
`define PMTA_PROG_TIME_US 2000
`define PMTA_CLK_MHZ 20

`endif

// ===== pmta_hold_block.v
`timescale 1ns/1ps
`include "pmta_defs.vh"

// ----------------------------------------
// holding register block for flash writes
// ----------------------------------------
module pmta_hold_block #(
    parameter SLOT_BITS = 5
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire wr_in,
    input wire [SLOT_BITS-1:0] slot_in,
    input wire [7:0] byte_in,
    input wire clear_in,
    output wire [(8<<SLOT_BITS)-1:0] block_out
);
    localparam SLOTS = 1 << SLOT_BITS;

    reg [7:0] slot_mem [0:SLOTS-1];
    integer i;
    genvar g;

    // erased flash reads as ones, so an unwritten slot stays all ones
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < SLOTS; i = i + 1) begin
                slot_mem[i] <= 8'hff;
            end
        end else if (clear_in) begin
            for (i = 0; i < SLOTS; i = i + 1) begin
                slot_mem[i] <= 8'hff;
            end
        end else if (wr_in) begin
            slot_mem[slot_in] <= byte_in;
        end
    end

    generate
        for (g = 0; g < SLOTS; g = g + 1) begin : flat
            assign block_out[g*8 +: 8] = slot_mem[g];
        end
    endgenerate
endmodule

// ===== pmta_prog_timer.v
`timescale 1ns/1ps
`include "pmta_defs.vh"

// ----------------------------------------
// internal programming timer
// ----------------------------------------
module pmta_prog_timer #(
    parameter CYCLES = 40000
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire start_in,
    output wire busy_out,
    output reg done_out
);
    reg [31:0] remain;

    assign busy_out = (remain != 32'h0);

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remain <= 32'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                remain <= CYCLES;
            end else if (remain != 32'h0) begin
                remain <= remain - 32'h1;
                done_out <= (remain == 32'h1);
            end
        end
    end
endmodule

// ===== pmta_monitor.sv
`timescale 1ns/1ps
`include "pmta_defs.vh"
module pmta_monitor #(
    parameter PROG_BYTES = 32'h00010000,
    parameter SLOT_BITS = 5
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [20:0] fetch_addr_in,
    input wire [20:0] fetch_mem_addr_out,
    input wire [15:0] fetch_mem_data_in,
    input wire [15:0] fetch_data_out,
    input wire [20:0] reset_vector_out,
    input wire [20:0] high_vector_out,
    input wire [20:0] low_vector_out,
    input wire [2:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_wdata_in,
    input wire [7:0] sfr_rdata_out,
    input wire table_read_op_in,
    input wire table_busy_out,
    input wire nv_start_out,
    input wire [1:0] nv_kind_out,
    input wire [21:0] nv_addr_out,
    input wire memory_done_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // a clearing write loses against a same-edge set
    wire flag_clr = sfr_wr_in && sfr_addr_in == `PMTA_REG_FLAGS7 && !sfr_wdata_in[`PMTA_FLAGS7_DONE];
    a_vector_values: assert property (
        reset_vector_out == 21'h0 && high_vector_out == 21'h8 && low_vector_out == 21'h18) else $error("bad vector");
    a_fetch_bus: assert property (fetch_mem_addr_out == fetch_addr_in)
        else $error("fetch address not passed");
    a_fetch_data: assert property (1'b1 |=> fetch_data_out ==
        ($past(fetch_addr_in) >= PROG_BYTES ? 16'h0 : $past(fetch_mem_data_in))) else $error("bad fetch data");
    a_unlock_zero: assert property (sfr_rd_in && sfr_addr_in == `PMTA_REG_UNLOCK |=> sfr_rdata_out == 8'h0)
        else $error("unlock port not zero");
    a_launch_gap: assert property (nv_start_out |=> !nv_start_out [*8])
        else $error("launch while busy");
    a_flash_align: assert property (nv_start_out && nv_kind_out inside {2'h1, 2'h2} |->
        nv_addr_out[SLOT_BITS-1:0] == '0) else $error("flash address not aligned");
    a_done_holds: assert property (memory_done_flag_out && !flag_clr |=> memory_done_flag_out)
        else $error("done flag dropped");
    a_read_busy: assert property (table_read_op_in && !table_busy_out |=> table_busy_out ##1 !table_busy_out)
        else $error("bad read busy");
    c_launch: cover property (nv_start_out);
    c_done: cover property ($rose(memory_done_flag_out));
    c_read: cover property (table_busy_out);
endmodule

bind pmta_table_access pmta_monitor #(.PROG_BYTES(PROG_BYTES), .SLOT_BITS(SLOT_BITS)) u_mon (.clk_in, .rst_n_in,
    .fetch_addr_in, .fetch_mem_addr_out, .fetch_mem_data_in, .fetch_data_out, .reset_vector_out, .high_vector_out,
    .low_vector_out, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .table_read_op_in,
    .table_busy_out, .nv_start_out, .nv_kind_out, .nv_addr_out, .memory_done_flag_out);

// ===== pmta_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// program array as seen by the core
// ----------------------------------------
module pmta_mem_model (
    input wire [20:0] fetch_addr_in,
    input wire [21:0] table_addr_in,
    output wire [15:0] fetch_word_out,
    output wire [7:0] table_byte_out
);
    // patterns mix high and low bits so a wrong address bit shows
    assign fetch_word_out = {fetch_addr_in[7:0] ^ fetch_addr_in[20:13], ~fetch_addr_in[15:8]};
    assign table_byte_out = table_addr_in[7:0] ^ table_addr_in[15:8] ^ {2'h0, table_addr_in[21:16]};
endmodule

// ===== pmta_table_access_tb_top.sv
`timescale 1ns/1ps
`include "pmta_defs.vh"
module pmta_table_access_tb_top;
    localparam int PB = 32'h00010000;
    logic clk_in = 0;
    logic rst_n_in = 0;
    logic [20:0] fa = '0;
    logic [2:0] sa = '0;
    logic swr = 0, srd = 0, rop = 0, wop = 0;
    logic [7:0] wd = '0;
    logic [1:0] upd = '0;
    wire [20:0] fma, rv, hv, lv;
    wire [15:0] fmd, fdo;
    wire [7:0] rdat, tmd, nvb;
    wire [21:0] tma, nva;
    wire busy, nvs, flag;
    wire [1:0] nvk;
    wire [255:0] blk;
    int bad_count = 0, compares = 0, ptr = 0, n;
    logic [7:0] latch = 0;
    logic [7:0] hold [32];
    always #25 clk_in = ~clk_in;
    pmta_table_access #(.PROG_TIME_US(1)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .fetch_addr_in(fa),
        .fetch_mem_addr_out(fma), .fetch_mem_data_in(fmd), .fetch_data_out(fdo), .reset_vector_out(rv),
        .high_vector_out(hv), .low_vector_out(lv), .sfr_addr_in(sa), .sfr_wr_in(swr), .sfr_rd_in(srd),
        .sfr_wdata_in(wd), .sfr_rdata_out(rdat), .table_read_op_in(rop), .table_write_op_in(wop),
        .table_update_in(upd), .table_busy_out(busy), .table_mem_addr_out(tma), .table_mem_data_in(tmd),
        .nv_start_out(nvs), .nv_kind_out(nvk), .nv_addr_out(nva), .nv_byte_out(nvb), .nv_block_out(blk),
        .memory_done_flag_out(flag));
    pmta_mem_model mem (.fetch_addr_in(fma), .table_addr_in(tma), .fetch_word_out(fmd), .table_byte_out(tmd));
    // ----------------------------------------
    // reference model and bus tasks
    // ----------------------------------------
    function automatic logic [7:0] mbyte(input int a);
        if (a[21] == 0 && a[20:0] >= PB)
            return 8'h0;
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
    endfunction
    task tick;
        @(posedge clk_in);
        #2;
    endtask
    task end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t byte %h exp %h", $time, g, e);
        end
    endtask
    task chkw(input logic [21:0] g, input logic [21:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t value %h exp %h", $time, g, e);
        end
    endtask
    task sfr_wr(input logic [2:0] a, input logic [7:0] v);
        tick;
        sa = a;
        wd = v;
        swr = 1;
        tick;
        swr = 0;
    endtask
    task sfr_rd(input logic [2:0] a, input logic [7:0] e);
        tick;
        sa = a;
        srd = 1;
        tick;
        srd = 0;
        chk8(rdat, e);
    endtask
    task set_ptr(input int p);
        ptr = p & 32'h3fffff;
        sfr_wr(3, p[7:0]);
        sfr_wr(4, p[15:8]);
        sfr_wr(5, p[23:16]);
    endtask
    task chk_ptr;
        sfr_rd(3, ptr[7:0]);
        sfr_rd(4, ptr[15:8]);
        sfr_rd(5, {2'h0, ptr[21:16]});
    endtask
    // pre-increment accesses pointer plus one; bit 21 never moves
    task top(input bit rd, input logic [1:0] m);
        int a;
        a = (m == 3) ? (ptr & 32'h200000) | ((ptr + 1) & 32'h1fffff) : ptr;
        tick;
        upd = m;
        rop = rd;
        wop = !rd;
        tick;
        rop = 0;
        wop = 0;
        if (m != 0)
            ptr = (ptr & 32'h200000) | ((m == 2 ? ptr - 1 : ptr + 1) & 32'h1fffff);
        if (rd) begin
            chkw(tma, a);
            chkw(busy, 1);
            latch = mbyte(a);
        end else
            hold[a[4:0]] = latch;
    endtask
    task run(input logic [7:0] c, input logic [1:0] k);
        sfr_wr(0, c | 8'h04);
        sfr_wr(0, c | 8'h06);
        chkw(nvs, 1);
        chkw(nvk, k);
        chkw(nva, (k == 1 || k == 2) ? ptr & 32'h3fffe0 : ptr);
        chk8(nvb, latch);
        sfr_wr(0, c | 8'h04);
        sfr_rd(0, c | 8'h0e);
        n = 0;
        while (flag !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        if (n == 100) begin
            bad_count++;
            end_of_test;
        end
        sfr_rd(0, c | 8'h04);
        sfr_rd(6, 8'h20);
        sfr_wr(6, 8'h00);
        sfr_rd(6, 8'h00);
        for (n = 0; n < 32 && k == 1; n++) begin
            hold[n] = 8'hff;
            chk8(blk[8*n +: 8], 8'hff);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (n = 0; n < 32; n++)
            hold[n] = 8'hff;
        n = $urandom(22);
        repeat (8) @(posedge clk_in);
        #2 rst_n_in = 1;
        for (int i = 0; i < 8; i++)
            sfr_rd(i[2:0], 8'h00);
        chkw(rv, 0);
        chkw(hv, 8);
        chkw(lv, 8'h18);
        for (int i = 0; i < 8; i++) begin
            fa = i[0] ? $urandom_range(21'h1fffff, PB) : $urandom_range(PB - 1);
            tick;
            chkw(fdo, i[0] ? 0 : {fa[7:0] ^ fa[20:13], ~fa[15:8]});
        end
        sfr_wr(1, 8'hff);
        sfr_rd(1, 8'h00);
        sfr_wr(7, 8'hff);
        sfr_rd(7, 8'h00);
        set_ptr(32'h3fffff);
        for (int i = 0; i < 8; i++) begin
            top(1, i[1:0]);
            sfr_rd(2, latch);
            chk_ptr;
            if (i == 3)
                set_ptr($urandom_range(PB + 1, PB - 2));
        end
        set_ptr($urandom & 32'h1fffe0 | 32'h1b);
        for (int i = 0; i < 8; i++) begin
            latch = $urandom;
            sfr_wr(2, latch);
            top(0, 2'h1);
        end
        for (n = 0; n < 32; n++)
            chk8(blk[8*n +: 8], hold[n]);
        run(8'h80, 1);
        run(8'h90, 2);
        run(8'h00, 0);
        run(8'h10, 0);
        run(8'h40, 3);
        run(8'hc0, 3);
        sfr_wr(0, 8'h80);
        sfr_wr(0, 8'h82);
        chkw(nvs, 0);
        sfr_rd(0, 8'h80);
        end_of_test;
    end
endmodule
